// ### shared/tlic_pkg.sv
// shared constants and types of the two-level interrupt controller
`default_nettype none
package tlic_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADDR_ENABLE_MAIN   = 8'hA8;
  localparam logic [7:0] ADDR_PRIORITY_MAIN = 8'hB8;
  localparam logic [7:0] ADDR_REQUEST_FLAGS = 8'hC0;
  localparam logic [7:0] ADDR_P1_ENABLE     = 8'hE8;
  localparam logic [7:0] ADDR_P1_POLARITY   = 8'hE9;
  localparam logic [7:0] ADDR_P1_PRIORITY   = 8'hF8;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int          GATE_BIT     = 7;
  localparam int          EXT0_BIT     = 0;
  localparam int          TMR0_BIT     = 1;
  localparam int          EXT1_BIT     = 2;
  localparam int          TMR1_BIT     = 3;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam int          NUM_SOURCES  = 12;
  // ****************************************
  // vectors
  // ****************************************
  localparam logic [15:0] VEC_EXT0     = 16'h0003;
  localparam logic [15:0] VEC_TMR0     = 16'h000B;
  localparam logic [15:0] VEC_EXT1     = 16'h0013;
  localparam logic [15:0] VEC_TMR1     = 16'h001B;
  localparam logic [15:0] VEC_P1_BASE  = 16'h003B;
  localparam logic [15:0] VEC_P1_STEP  = 16'h0008;

  // source index order: 0 ext0, 1 tmr0, 2 ext1, 3 tmr1, 4..11 ext2..ext9
  typedef logic [NUM_SOURCES-1:0] tlic_src_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tlic_bus_type;

  typedef struct packed {
    logic        valid;
    logic        high;
    logic [3:0]  index;
    logic [15:0] vector;
  } tlic_grant_type;

  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} tlic_level_type;
endpackage
`default_nettype wire

// ### sim/tb_tlic_top.sv
// self-checking testbench of the two-level interrupt controller
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin num_errors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_tlic_top
  import tlic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i, reset_n_i, reg_wr_i, reg_rd_i, ext0_irq_i, ext_irq_one_input;
  logic timer0_overflow_flag, timer1_overflow_flag, irq_ack_i, irq_return_i, irq_req_o;
  logic wake_o, idle_exit_o, auto_ack, ret_cmd, cap_idle;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, port1_irq_inputs, em, ep, rd_v;
  logic [15:0] irq_vector_o, cap_vec;
  logic [3:0] irq_source_o, cap_src;
  logic [1:0] service_level_o;
  int num_errors, checked, i;
  localparam logic [7:0] ADR [6] = '{ADDR_ENABLE_MAIN, ADDR_PRIORITY_MAIN,
    ADDR_REQUEST_FLAGS, ADDR_P1_ENABLE, ADDR_P1_POLARITY, ADDR_P1_PRIORITY};
  localparam logic [7:0] MSK [6] = '{8'h8F, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [3:0] ORD [12] = '{4'h0, 4'h7, 4'h1, 4'h8, 4'h2, 4'h4, 4'h9, 4'h3,
    4'h5, 4'hA, 4'h6, 4'hB};
  tlic_top dut (.core_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .ext0_irq_i, .ext_irq_one_input, .timer0_overflow_flag,
    .timer1_overflow_flag, .port1_irq_inputs, .irq_ack_i, .irq_return_i, .irq_req_o,
    .irq_vector_o, .irq_source_o, .wake_o, .idle_exit_o, .service_level_o);
  tlic_core_model core (.core_clk_i, .reset_n_i, .irq_req_i(irq_req_o),
    .auto_ack_i(auto_ack), .ret_cmd_i(ret_cmd), .irq_ack_o(irq_ack_i),
    .irq_return_o(irq_return_i));
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  function automatic logic [15:0] vec(input logic [3:0] s);
    vec = (s < 4) ? 16'h0003 + 16'h0008 * s : 16'h003B + 16'h0008 * (s - 4);
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 rd_v = reg_rdata_o;
    @(posedge core_clk_i);
  endtask
  task automatic ret();
    ret_cmd <= 1'b1;
    @(posedge core_clk_i);
    ret_cmd <= 1'b0;
    @(posedge core_clk_i);
  endtask
  // what: 0 offer, 1 service level, 2 wake; the offer is captured while it stands
  task automatic wait_for(input int what, input logic [1:0] v);
    logic [1:0] s;
    for (int n = 0; n < 60; n++) begin
      @(posedge core_clk_i);
      #1 s = what == 0 ? {1'b0, irq_req_o} : what == 1 ? service_level_o : {1'b0, wake_o};
      cap_src = irq_source_o;
      cap_vec = irq_vector_o;
      cap_idle = idle_exit_o;
      if (s === v) break;
    end
    checked++;
    if (s !== v) begin
      num_errors++;
      $display("Error wait_for %0d expected %h seen %h", what, v, s);
      end_of_test();
    end
    @(posedge core_clk_i);
  endtask
  initial begin
    {reset_n_i, reg_wr_i, reg_rd_i, auto_ack, ret_cmd} = 5'h00;
    {ext0_irq_i, ext_irq_one_input, timer0_overflow_flag, timer1_overflow_flag} = 4'h0;
    {reg_addr_i, reg_wdata_i} = 16'h0000;
    port1_irq_inputs = 8'hFF;
    repeat (12) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
    for (i = 0; i < 6; i++) begin
      rd(ADR[i]);
      `CHK("reset value", 8'h00, rd_v)
      wr(ADR[i], 8'hFF);
      rd(ADR[i]);
      `CHK("register", MSK[i], rd_v)
      wr(ADR[i], 8'h00);
    end
    wr(ADDR_REQUEST_FLAGS, 8'h00);
    wr(8'h55, 8'hFF);
    rd(8'h55);
    `CHK("unmapped", 8'h00, rd_v)
    $display("test 1 done");
    port1_irq_inputs <= 8'hF7;
    repeat (4) @(posedge core_clk_i);
    rd(ADDR_REQUEST_FLAGS);
    `CHK("flag set", 8'h08, rd_v)
    port1_irq_inputs <= 8'hFF;
    repeat (4) @(posedge core_clk_i);
    rd(ADDR_REQUEST_FLAGS);
    `CHK("flag kept", 8'h08, rd_v)
    wr(ADDR_REQUEST_FLAGS, 8'h00);
    rd(ADDR_REQUEST_FLAGS);
    `CHK("flag cleared", 8'h00, rd_v)
    wr(ADDR_P1_POLARITY, 8'hFF);
    wr(ADDR_REQUEST_FLAGS, 8'h00);
    rd(ADDR_REQUEST_FLAGS);
    `CHK("level held", 8'hFF, rd_v)
    port1_irq_inputs <= 8'h00;
    wr(ADDR_REQUEST_FLAGS, 8'h00);
    rd(ADDR_REQUEST_FLAGS);
    `CHK("high polarity", 8'h00, rd_v)
    $display("test 2 done");
    wr(ADDR_P1_ENABLE, 8'h01);
    port1_irq_inputs <= 8'h01;
    wait_for(2, 2'h1);
    wr(ADDR_ENABLE_MAIN, 8'h80);
    wait_for(0, 2'h1);
    `CHK("pin source", 4'h4, cap_src)
    `CHK("idle exit", 1'b1, cap_idle)
    auto_ack <= 1'b1;
    wait_for(1, 2'h1);
    auto_ack <= 1'b0;
    ret();
    wait_for(0, 2'h1);
    `CHK("again", 4'h4, cap_src)
    auto_ack <= 1'b1;
    wait_for(1, 2'h1);
    rd(ADDR_REQUEST_FLAGS);
    `CHK("kept on vectoring", 8'h01, rd_v)
    port1_irq_inputs <= 8'h00;
    wr(ADDR_REQUEST_FLAGS, 8'h00);
    ret();
    wait_for(1, 2'h0);
    $display("test 3 done");
    {ext0_irq_i, ext_irq_one_input, timer0_overflow_flag, timer1_overflow_flag} <= 4'hF;
    port1_irq_inputs <= 8'hFF;
    em = 8'h8F;
    ep = 8'hFF;
    wr(ADDR_ENABLE_MAIN, 8'h0F);
    wr(ADDR_P1_ENABLE, ep);
    wr(ADDR_ENABLE_MAIN, em);
    for (i = 0; i < 12; i++) begin
      wait_for(0, 2'h1);
      `CHK("order", ORD[i], cap_src)
      `CHK("vector", vec(ORD[i]), cap_vec)
      wait_for(1, 2'h1);
      if (ORD[i] < 4) em[ORD[i]] = 1'b0;
      else ep[ORD[i] - 4] = 1'b0;
      wr(ADDR_ENABLE_MAIN, em);
      wr(ADDR_P1_ENABLE, ep);
      ret();
    end
    $display("test 4 done");
    wr(ADDR_ENABLE_MAIN, 8'h84);
    wait_for(0, 2'h1);
    `CHK("low source", 4'h2, cap_src)
    wait_for(1, 2'h1);
    wr(ADDR_PRIORITY_MAIN, 8'h02);
    wr(ADDR_ENABLE_MAIN, 8'h86);
    wait_for(0, 2'h1);
    `CHK("preempt", 4'h1, cap_src)
    wait_for(1, 2'h2);
    wr(ADDR_PRIORITY_MAIN, 8'h03);
    wr(ADDR_ENABLE_MAIN, 8'h87);
    repeat (4) @(posedge core_clk_i);
    auto_ack <= 1'b0;
    ret();
    wait_for(0, 2'h1);
    `CHK("after high", 4'h0, cap_src)
    $display("test 5 done");
    end_of_test();
  end
endmodule
`default_nettype wire

// ### sim/tlic_assertions.sv
// port checker of the two-level interrupt controller
`default_nettype none
module tlic_checker
  import tlic_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        reset_n_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        ext0_irq_i,
  input wire logic        ext_irq_one_input,
  input wire logic        timer0_overflow_flag,
  input wire logic        timer1_overflow_flag,
  input wire logic [7:0]  port1_irq_inputs,
  input wire logic        irq_ack_i,
  input wire logic        irq_return_i,
  input wire logic        irq_req_o,
  input wire logic [15:0] irq_vector_o,
  input wire logic [3:0]  irq_source_o,
  input wire logic        wake_o,
  input wire logic        idle_exit_o,
  input wire logic [1:0]  service_level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       gate_q;
  logic [7:0] p1en_q;
  // enable shadows rebuilt from writes, since register state is not at the ports
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      gate_q <= 1'b0;
      p1en_q <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == ADDR_ENABLE_MAIN) begin
      gate_q <= reg_wdata_i[GATE_BIT];
    end else if (reg_wr_i && reg_addr_i == ADDR_P1_ENABLE) begin
      p1en_q <= reg_wdata_i;
    end
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  a_gate_blocks: assert property (!gate_q && !$past(gate_q) |-> !irq_req_o)
    else $error("offer while gate clear");
  a_vector_map: assert property (irq_req_o |-> irq_vector_o == (irq_source_o < 4'h4 ?
    16'h0003 + 16'h0008 * irq_source_o : 16'h003B + 16'h0008 * (irq_source_o - 4'h4)))
    else $error("vector does not fit source");
  a_high_holds: assert property (service_level_o == 2'h2 && $past(service_level_o) == 2'h2
    |-> !irq_req_o) else $error("offer during high service");
  a_ack_drops: assert property (irq_ack_i && irq_req_o |=> !irq_req_o)
    else $error("offer kept after ack");
  a_ack_enters: assert property (irq_ack_i && irq_req_o |=> service_level_o != 2'h0)
    else $error("ack left no service level");
  a_ret_low: assert property (irq_return_i && service_level_o == 2'h1 |=> service_level_o == 2'h0)
    else $error("low return kept level");
  a_wake_enable: assert property (wake_o |-> (p1en_q | $past(p1en_q)) != 8'h00)
    else $error("wake with no port 1 enable");
  a_idle_gate: assert property (idle_exit_o |-> gate_q || $past(gate_q))
    else $error("idle exit while gate clear");
endmodule
bind tlic_top tlic_checker u_chk (.*);
`default_nettype wire

// ### sim/tlic_core_model.sv
// core-side model: takes offered vectors and signals service routine returns
`default_nettype none
module tlic_core_model
  import tlic_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic reset_n_i,
  input  wire logic irq_req_i,
  input  wire logic auto_ack_i,
  input  wire logic ret_cmd_i,
  output logic      irq_ack_o,
  output logic      irq_return_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // no ack right after an ack: the offer is still up for that one cycle
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      irq_ack_o    <= 1'b0;
      irq_return_o <= 1'b0;
    end else begin
      irq_ack_o    <= irq_req_i && auto_ack_i && !irq_ack_o && !ret_cmd_i;
      irq_return_o <= ret_cmd_i;
    end
  end
endmodule
`default_nettype wire

// ### verilog/tlic_arbiter.sv
// fixed-order two-level arbiter producing the winning source and vector
`default_nettype none
module tlic_arbiter
  import tlic_pkg::*;
(
  input  wire logic           [NUM_SOURCES-1:0] req_i,
  input  wire logic           [NUM_SOURCES-1:0] high_i,
  output tlic_grant_type                        high_grant_o,
  output tlic_grant_type                        low_grant_o
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    case (idx)
      4'h0:    vec_of = VEC_EXT0;
      4'h1:    vec_of = VEC_TMR0;
      4'h2:    vec_of = VEC_EXT1;
      4'h3:    vec_of = VEC_TMR1;
      default: vec_of = 16'(VEC_P1_BASE + 16'(VEC_P1_STEP * 16'(idx - 4'h4))); // RULE2
    endcase
  endfunction

  // walk the fixed service order, first pending wins
  function automatic tlic_grant_type pick(input logic [NUM_SOURCES-1:0] r,
                                          input logic                   hi);
    logic [3:0] order [NUM_SOURCES];
    tlic_grant_type g;
    order = '{4'h0, 4'h7, 4'h1, 4'h8, 4'h2, 4'h4,
              4'h9, 4'h3, 4'h5, 4'hA, 4'h6, 4'hB};                  // RULE14
    g = '0;
    for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
      if (r[order[i]]) begin
        g.valid  = 1'b1;
        g.index  = order[i];
        g.vector = vec_of(order[i]);
      end
    end
    g.high = hi;
    return g;
  endfunction

  assign high_grant_o = pick(req_i & high_i, 1'b1);                 // RULE7
  assign low_grant_o  = pick(req_i & ~high_i, 1'b0);
endmodule
`default_nettype wire

// ### verilog/tlic_level_detect.sv
// level detection and request flag register of the eight port 1 interrupts
`default_nettype none
module tlic_level_detect
  import tlic_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] pins_i,
  input  wire logic [WIDTH-1:0] polarity_i,
  input  wire logic [WIDTH-1:0] enable_i,
  input  wire logic             flag_wr_i,
  input  wire logic [WIDTH-1:0] flag_wdata_i,
  output logic      [WIDTH-1:0] flags_o,
  output logic      [WIDTH-1:0] wake_o
);
  logic [WIDTH-1:0] active;
  logic [WIDTH-1:0] flags_d;
  logic [WIDTH-1:0] flags_q;

  // polarity bit 1 means active high, 0 active low; level, not edge
  assign active  = ~(pins_i ^ polarity_i);                          // RULE8 RULE10
  // a pin still active keeps setting its flag, so set wins over a clear
  assign flags_d = flag_wr_i ? (flag_wdata_i | active) : (flags_q | active); // RULE11 RULE12
  // wake is combinational here, but tlic_top registers it into wake_o on core_clk_i
  assign wake_o  = active & enable_i;                               // RULE9 RULE18
  assign flags_o = flags_q;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      flags_q <= WIDTH'(REG_RESET);                                 // RULE20
    end else begin
      flags_q <= flags_d;
    end
  end
endmodule
`default_nettype wire

// ### verilog/tlic_top.sv
// two-level interrupt controller: registers, gating, nesting and vector output
//
// What this block does
// (RULE1) twelve sources: ext 0, ext 1, timer 0, timer 1, ext 2 to 9
// (RULE2) each source has its own fixed vector address
// (RULE3) each source has an enable bit; disabled sources are never taken
// (RULE4) bit 7 of main enable register gates all interrupts
// (RULE5) port 1 enable bit 0 disables, 1 enables
// (RULE6) each source has its own priority bit
// (RULE7) priority bit 1 selects high level, 0 low level
// (RULE8) ext 2 to 9 are level sensitive
// (RULE9) an enabled ext 2 to 9 wakes the device from power-down
// (RULE10) polarity bit 0 means active low, 1 active high
// (RULE11) a recognised port 1 request sets its flag
// (RULE12) flags are cleared only by software writes, never on vectoring
// (RULE13) a flag still set at return raises the interrupt again
// (RULE14) fixed order resolves simultaneous same-level requests
// (RULE15) bit k of port 1 registers maps to ext k+2
// (RULE16) high pre-empts low; nothing interrupts high until it returns
// (RULE17) ext 2 to 9 come from port 1 pins in order
// (RULE18) power-down ends on reset or an enabled port 1 interrupt
// (RULE19) idle ends on any interrupt; logic stays clocked
// (RULE20) reset clears all enable, priority, polarity and flag registers
//
// The plain strobed port is this design's own decision.
`default_nettype none
module tlic_top
  import tlic_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        ext0_irq_i,
  input  wire logic        ext_irq_one_input,
  input  wire logic        timer0_overflow_flag,
  input  wire logic        timer1_overflow_flag,
  input  wire logic [7:0]  port1_irq_inputs,
  input  wire logic        irq_ack_i,
  input  wire logic        irq_return_i,
  output logic             irq_req_o,
  output logic      [15:0] irq_vector_o,
  output logic      [3:0]  irq_source_o,
  output logic             wake_o,
  output logic             idle_exit_o,
  output logic      [1:0]  service_level_o
);
  // ****************************************
  // register bus decode
  // ****************************************
  tlic_bus_type bus;
  logic         wr_en_main, wr_pr_main, wr_flags, wr_en_p1, wr_pol_p1, wr_pr_p1;
  logic [7:0]   rdata_d;

  // one driver for the whole carrier: fields are wr, rd, addr, wdata
  assign bus = {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i};

  assign wr_en_main = bus.wr && (bus.addr == ADDR_ENABLE_MAIN);
  assign wr_pr_main = bus.wr && (bus.addr == ADDR_PRIORITY_MAIN);
  assign wr_flags   = bus.wr && (bus.addr == ADDR_REQUEST_FLAGS);
  assign wr_en_p1   = bus.wr && (bus.addr == ADDR_P1_ENABLE);
  assign wr_pol_p1  = bus.wr && (bus.addr == ADDR_P1_POLARITY);
  assign wr_pr_p1   = bus.wr && (bus.addr == ADDR_P1_PRIORITY);

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] interrupt_enable_main_q;
  logic [7:0] interrupt_priority_main_q;
  logic [7:0] port1_interrupt_enable_q;
  logic [7:0] port1_interrupt_polarity_q;
  logic [7:0] port1_interrupt_priority_q;
  logic [7:0] port1_interrupt_request_flags;
  logic [7:0] p1_wake;

  // unused bits of the main enable register read back as zero
  localparam logic [7:0] ENABLE_MAIN_MASK   = 8'h8F;
  localparam logic [7:0] PRIORITY_MAIN_MASK = 8'h0F;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      interrupt_enable_main_q    <= REG_RESET;                      // RULE20
      interrupt_priority_main_q  <= REG_RESET;
      port1_interrupt_enable_q   <= REG_RESET;
      port1_interrupt_polarity_q <= REG_RESET;
      port1_interrupt_priority_q <= REG_RESET;
    end else begin
      if (wr_en_main) begin
        interrupt_enable_main_q <= bus.wdata & ENABLE_MAIN_MASK;    // RULE3 RULE4
      end
      if (wr_pr_main) begin
        interrupt_priority_main_q <= bus.wdata & PRIORITY_MAIN_MASK; // RULE6
      end
      if (wr_en_p1) begin
        port1_interrupt_enable_q <= bus.wdata;                      // RULE5
      end
      if (wr_pol_p1) begin
        port1_interrupt_polarity_q <= bus.wdata;                    // RULE10
      end
      if (wr_pr_p1) begin
        port1_interrupt_priority_q <= bus.wdata;                    // RULE6
      end
    end
  end

  // ****************************************
  // port 1 level detection and flags
  // ****************************************
  tlic_level_detect #(
    .WIDTH (8)
  ) u_detect (
    .core_clk_i   (core_clk_i),
    .reset_n_i    (reset_n_i),
    .pins_i       (port1_irq_inputs),                               // RULE17
    .polarity_i   (port1_interrupt_polarity_q),
    .enable_i     (port1_interrupt_enable_q),
    .flag_wr_i    (wr_flags),
    .flag_wdata_i (bus.wdata),
    .flags_o      (port1_interrupt_request_flags),
    .wake_o       (p1_wake)
  );

  // ****************************************
  // request gating
  // ****************************************
  logic [NUM_SOURCES-1:0] raw_req, src_en, src_high, gated_req;

  assign raw_req  = {port1_interrupt_request_flags,                 // RULE1 RULE15
                     timer1_overflow_flag, ext_irq_one_input,
                     timer0_overflow_flag, ext0_irq_i};
  assign src_en   = {port1_interrupt_enable_q,
                     interrupt_enable_main_q[TMR1_BIT], interrupt_enable_main_q[EXT1_BIT],
                     interrupt_enable_main_q[TMR0_BIT], interrupt_enable_main_q[EXT0_BIT]};
  assign src_high = {port1_interrupt_priority_q, interrupt_priority_main_q[3:0]}; // RULE6
  // flags stay set until software clears them, so an unserviced one repeats
  assign gated_req = interrupt_enable_main_q[GATE_BIT] ? (raw_req & src_en)  // RULE3 RULE4 RULE13
                                                       : '0;

  tlic_grant_type high_grant, low_grant, chosen;

  tlic_arbiter u_arb (
    .req_i        (gated_req),
    .high_i       (src_high),
    .high_grant_o (high_grant),
    .low_grant_o  (low_grant)
  );

  // ****************************************
  // nesting state
  // ****************************************
  tlic_level_type level_q, level_d;
  logic           saved_low_q;
  logic           took_high_q;
  logic           take;

  // while in high nothing is offered; in low only high is offered
  always_comb begin
    case (level_q)
      ST_IDLE: chosen = high_grant.valid ? high_grant : low_grant;  // RULE14
      ST_LOW:  chosen = high_grant;                                 // RULE16
      ST_HIGH: chosen = '0;                                         // RULE16
      default: chosen = '0;
    endcase
  end

  assign take = irq_ack_i && irq_req_o;

  always_comb begin
    level_d = level_q;
    case (level_q)
      ST_IDLE: begin
        if (take) begin
          // level of the offer registered beside irq_req_o, not of the live grant
          level_d = took_high_q ? ST_HIGH : ST_LOW;                   // RULE16
        end
      end
      ST_LOW: begin
        if (take) begin
          level_d = ST_HIGH;
        end else if (irq_return_i) begin
          level_d = ST_IDLE;
        end
      end
      ST_HIGH: begin
        if (irq_return_i) begin
          level_d = saved_low_q ? ST_LOW : ST_IDLE;
        end
      end
      default: level_d = ST_IDLE;
    endcase
  end

  // ****************************************
  // outputs
  // ****************************************
  always_comb begin
    rdata_d = REG_RESET;
    case (bus.addr)
      ADDR_ENABLE_MAIN:   rdata_d = interrupt_enable_main_q;
      ADDR_PRIORITY_MAIN: rdata_d = interrupt_priority_main_q;
      ADDR_REQUEST_FLAGS: rdata_d = port1_interrupt_request_flags;
      ADDR_P1_ENABLE:     rdata_d = port1_interrupt_enable_q;
      ADDR_P1_POLARITY:   rdata_d = port1_interrupt_polarity_q;
      ADDR_P1_PRIORITY:   rdata_d = port1_interrupt_priority_q;
      default:            rdata_d = REG_RESET;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      level_q         <= ST_IDLE;
      saved_low_q     <= 1'b0;
      took_high_q     <= 1'b0;
      irq_req_o       <= 1'b0;
      irq_vector_o    <= 16'h0000;
      irq_source_o    <= 4'h0;
      wake_o          <= 1'b0;
      idle_exit_o     <= 1'b0;
      service_level_o <= 2'b00;
      reg_rdata_o     <= REG_RESET;
    end else begin
      level_q         <= level_d;
      if (take && level_q == ST_LOW) begin
        saved_low_q <= 1'b1;
      end else if (level_d == ST_IDLE) begin
        saved_low_q <= 1'b0;
      end
      took_high_q     <= chosen.high;
      // the request drops for a cycle on an ack so a stale vector is never retaken
      irq_req_o       <= chosen.valid && !take && !irq_return_i;
      irq_vector_o    <= chosen.vector;                             // RULE2
      irq_source_o    <= chosen.index;
      wake_o          <= |p1_wake;                                  // RULE9 RULE18
      idle_exit_o     <= |gated_req;                                // RULE19
      service_level_o <= level_d;
      reg_rdata_o     <= bus.rd ? rdata_d : REG_RESET;
    end
  end
endmodule
`default_nettype wire
